// >>> shared/ipr_pkg.sv
// ipr_pkg: constants and state encodings shared by the interrupt
// posting and priority resolver.
// assumes a byte-addressed register port with 32-bit data words.
package ipr_pkg;

   // priorities and vectors
   localparam int             VEC_W        = 8;
   localparam int             PRI_W        = 5;
   localparam int             PRI_SHIFT    = 3;        // priority = vector / 8
   localparam logic [4:0]     PRI_TOP      = 5'h1F;    // priority 31
   localparam logic [4:0]     PRI_NONE     = 5'h00;
   localparam logic [7:0]     MSG_POST     = 8'h00;    // request-interrupt message type
   localparam logic [7:0]     CHECK_VEC_MAX = 8'h07;   // vectors 0..7 only force a check

   // pending area of the table
   localparam int             PEND_WORDS   = 8;        // 256 pending bits
   localparam int             PEND_BITS    = 256;
   localparam int             PEND_IDX_W   = 3;

   // register map (byte addresses)
   localparam logic [7:0]     ADDR_PRI        = 8'h00; // pending-priority word
   localparam logic [7:0]     ADDR_PEND_FIRST = 8'h04; // pending bits, vectors 0..31
   localparam logic [7:0]     ADDR_PEND_LAST  = 8'h20; // pending bits, vectors 224..255
   localparam logic [7:0]     ADDR_INTERRUPT_CONTROL_REGISTER       = 8'h24;
   localparam logic [7:0]     ADDR_MASK       = 8'h28;
   localparam logic [7:0]     ADDR_LOCK       = 8'h2C;
   localparam logic [7:0]     ADDR_STAT       = 8'h30;

   // field positions
   localparam int             INTERRUPT_CONTROL_REGISTER_CLR_BIT = 0;
   localparam int             LOCK_BIT     = 0;
   localparam int             STAT_BUSY    = 0;
   localparam int             STAT_LOCK    = 1;

   // reset values
   localparam logic [31:0]    RST_WORD     = 32'h0000_0000;

   // table-check sequencer, one-hot
   typedef enum logic [5:0] {
      ST_IDLE = 6'h01,
      ST_POST = 6'h02,
      ST_PEEK = 6'h04,
      ST_LOCK = 6'h08,
      ST_BYTE = 6'h10,
      ST_SPR  = 6'h20
   } ipr_state_type;

endpackage

// >>> hdl/ipr_msb_find.sv
// ipr_msb_find: index of the most significant set bit of a word.
// assumes nothing about its surroundings; purely combinational.
`timescale 1ns/1ps
`default_nettype none
module ipr_msb_find #(
   parameter int W  = 32,
   parameter int IW = 5
) (
   // operand
   input  wire logic [W-1:0]  vec_in,
   // result
   output logic      [IW-1:0] msb_idx,
   output logic               any_set
);

   logic [IW-1:0] chain [W:0];

   assign chain[0] = '0;

   // later stages override earlier ones, so the top set bit wins
   genvar i;
   generate
      for (i = 0; i < W; i++)
      begin : g_bit
         assign chain[i+1] = vec_in[i] ? IW'(i) : chain[i];
      end
   endgenerate

   assign msb_idx = chain[W];
   assign any_set = |vec_in;

endmodule
`default_nettype wire

// >>> hdl/ipr_mask_save.sv
// ipr_mask_save: hardware interrupt mask with save and optional clear
// on entry to a pin or timer handler.
// assumes hw_service is a one-cycle pulse from the core.
`timescale 1ns/1ps
`default_nettype none
module ipr_mask_save #(
   parameter int MW = 8
) (
   // clock and reset
   input  wire logic          ref_clk,
   input  wire logic          rst_n,
   input  wire logic          ce,
   // software write
   input  wire logic          wr_en,
   input  wire logic [MW-1:0] wdata,
   // handler entry
   input  wire logic          hw_service,
   input  wire logic          clear_opt,
   // state
   output logic      [MW-1:0] hardware_interrupt_mask,
   output logic      [MW-1:0] saved_mask_local_register
);

   typedef struct packed {
      logic [MW-1:0] mask;
      logic [MW-1:0] saved;
   } ipr_mask_state_type;

   ipr_mask_state_type q;
   ipr_mask_state_type d;

   // next state: entry saves and maybe clears, software write otherwise
   always_comb
   begin
      d = q;
      if (hw_service)
      begin
         d.saved = q.mask;
         if (clear_opt)
            d.mask = '0;
      end
      else if (wr_en)
         d.mask = wdata;
   end

   // state register, frozen while ce is low
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         q <= '0;
      else if (ce)
         q <= d;
   end

   assign hardware_interrupt_mask   = q.mask;
   assign saved_mask_local_register = q.saved;

endmodule
`default_nettype wire

// >>> hdl/ipr_resolver.sv
// ipr_resolver: interrupt posting, pending-table check and priority
// resolution between software, hardware and the running process.
// assumes the core holds off new requests while busy is high.
//
// Functional notes
// - post sets pending and priority bits atomically
// - after post, load highest pending priority
// - signal software interrupt when its priority largest
// - service clears bits, then reloads priority register
// - same level: highest vector goes first
// - software priority changes only on post/service
// - interrupt above current priority, or at 31
// - hardware wins ties at equal priority
// - software 31 preempts hardware 31 handler entry
// - table checked only on post or service
// - peek, then locked recheck before taking
// - locked: clear top bit, fix priority word
// - read byte only when its priority bit set
// - vectors 0..7 just force a table check
// - handler entry saves mask into local register
// - mask cleared on entry when option set
// - unmasked level 31 source re-enters handler
// - return never restores the saved mask
// - priority is vector divided by eight
// - priority word then 256 pending bits
//
// Decided for this implementation: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module ipr_resolver #(
   parameter int MW = 8
) (
   // clock, reset, enable
   input  wire logic          ref_clk,
   input  wire logic          rst_n,
   input  wire logic          ce,
   // register port
   input  wire logic [7:0]    reg_addr,
   input  wire logic [31:0]   reg_wdata,
   input  wire logic          reg_wr,
   input  wire logic          reg_rd,
   output logic      [31:0]   reg_rdata,
   // software post request from the core
   input  wire logic          post_req,
   input  wire logic [7:0]    post_msg,
   input  wire logic [7:0]    post_vec,
   output logic               busy,
   // priorities from the core and hardware sources
   input  wire logic [4:0]    cur_pri,
   input  wire logic [4:0]    hw_pend_pri,
   // software interrupt handshake
   output logic               sw_int_req,
   input  wire logic          sw_ack,
   output logic               taken_valid,
   output logic      [7:0]    taken_vector,
   // hardware interrupt handshake
   output logic               hw_int_req,
   input  wire logic          hw_ack,
   input  wire logic          hw_ack_pin_timer,
   input  wire logic          handler_first_insn,
   // mask
   output logic      [MW-1:0] hardware_interrupt_mask,
   output logic      [MW-1:0] saved_mask_local_register
);

   typedef struct packed {
      ipr_pkg::ipr_state_type     st;
      logic                       svc;        // check runs for a service
      logic [31:0]                pri;        // pending-priority word
      logic [ipr_pkg::PEND_BITS-1:0] pend;    // one bit per vector
      logic [4:0]                 spr;        // hidden software priority
      logic [4:0]                 y;          // level under examination
      logic [7:0]                 vec;        // vector being posted
      logic                       agent_lock;
      logic                       hw_entry;   // hardware handler entered
      logic                       interrupt_control_register_clr;
      logic [31:0]                rdata;
      logic                       taken;
      logic [7:0]                 taken_vec;
   } ipr_core_state_type;

   ipr_core_state_type q;
   ipr_core_state_type d;

   logic [4:0]                    pri_msb;
   logic                          pri_any;
   logic [4:0]                    nxt_msb;
   logic                          nxt_any;
   logic [7:0]                    cur_byte;
   logic [2:0]                    byte_msb;
   logic                          byte_any;
   logic [7:0]                    byte_cleared;
   logic [31:0]                   pri_after;
   logic                          tbl_wr;
   logic                          pend_hit;
   logic [ipr_pkg::PEND_IDX_W-1:0] pend_idx;
   logic                          dev_go;
   logic                          grant_ok;
   logic                          peek_exit;
   logic                          mask_wr;

   // top pending level in the current word
   ipr_msb_find #(
      .W  (32),
      .IW (5)
   ) u_pri_msb (
      .vec_in  (q.pri),
      .msb_idx (pri_msb),
      .any_set (pri_any)
   );

   // top pending level once the byte step has run
   ipr_msb_find #(
      .W  (32),
      .IW (5)
   ) u_nxt_msb (
      .vec_in  (pri_after),
      .msb_idx (nxt_msb),
      .any_set (nxt_any)
   );

   // highest vector within the chosen level
   ipr_msb_find #(
      .W  (8),
      .IW (3)
   ) u_byte_msb (
      .vec_in  (cur_byte),
      .msb_idx (byte_msb),
      .any_set (byte_any)
   );

   // mask register with save and clear on handler entry
   ipr_mask_save #(
      .MW (MW)
   ) u_mask (
      .ref_clk                   (ref_clk),
      .rst_n                     (rst_n),
      .ce                        (ce),
      .wr_en                     (mask_wr),
      .wdata                     (reg_wdata[MW-1:0]),
      .hw_service                (hw_ack && hw_ack_pin_timer),
      .clear_opt                 (q.interrupt_control_register_clr),
      .hardware_interrupt_mask   (hardware_interrupt_mask),
      .saved_mask_local_register (saved_mask_local_register)
   );

   // address decode of the pending area and mask
   assign pend_hit = (reg_addr >= ipr_pkg::ADDR_PEND_FIRST)
                  && (reg_addr <= ipr_pkg::ADDR_PEND_LAST)
                  && (reg_addr[1:0] == 2'h0);
   assign pend_idx = ipr_pkg::PEND_IDX_W'((reg_addr - ipr_pkg::ADDR_PEND_FIRST) >> 2);
   assign tbl_wr   = reg_wr && (pend_hit || reg_addr == ipr_pkg::ADDR_PRI);
   assign mask_wr  = reg_wr && (reg_addr == ipr_pkg::ADDR_MASK);

   // device posts or starts the locked recheck only with no agent lock and no bus write to the table; the byte step does not wait
   assign dev_go   = !q.agent_lock && !tbl_wr;
   assign grant_ok = !(q.st inside {ipr_pkg::ST_POST, ipr_pkg::ST_LOCK,
                                    ipr_pkg::ST_BYTE});

   // byte of the examined level and its top-bit-cleared form
   assign cur_byte = q.pend[{q.y, 3'h0} +: 8];
   always_comb
   begin
      byte_cleared = cur_byte;
      byte_cleared[byte_msb] = 1'b0;
   end

   // priority word after the byte step
   always_comb
   begin
      pri_after = q.pri;
      if (!byte_any || byte_cleared == 8'h00)
         pri_after[q.y] = 1'b0;
   end

   // nothing pending, or top level not above the process and not 31
   assign peek_exit = !pri_any
                   || (pri_msb != ipr_pkg::PRI_TOP && pri_msb <= cur_pri);

   // software request: largest of the three, hardware wins ties except a 31 tie during hardware entry
   always_comb
   begin
      sw_int_req = (q.st == ipr_pkg::ST_IDLE)
                && (q.spr != ipr_pkg::PRI_NONE)
                && (q.spr > cur_pri || q.spr == ipr_pkg::PRI_TOP)
                && (q.spr > hw_pend_pri
                    || (q.spr == ipr_pkg::PRI_TOP && q.hw_entry));
   end

   // hardware request; an active unmasked 31 source keeps re-entering
   assign hw_int_req = (hw_pend_pri != ipr_pkg::PRI_NONE)
                    && (hw_pend_pri > cur_pri
                        || hw_pend_pri == ipr_pkg::PRI_TOP);

   // next state
   always_comb
   begin
      d = q;
      d.taken = 1'b0;
      d.rdata = ipr_pkg::RST_WORD;

      // register reads, data stands the following cycle only
      if (reg_rd)
      begin
         if (pend_hit)
            d.rdata = q.pend[{pend_idx, 5'h00} +: 32];
         else
         begin
            case (reg_addr)
               ipr_pkg::ADDR_PRI:
                  d.rdata = q.pri;
               ipr_pkg::ADDR_INTERRUPT_CONTROL_REGISTER:
                  d.rdata[ipr_pkg::INTERRUPT_CONTROL_REGISTER_CLR_BIT] = q.interrupt_control_register_clr;
               ipr_pkg::ADDR_MASK:
                  d.rdata[MW-1:0] = hardware_interrupt_mask;
               ipr_pkg::ADDR_LOCK:
               begin
                  // reading the lock is the agent's atomic acquire
                  if (grant_ok)
                     d.agent_lock = 1'b1;
                  d.rdata[ipr_pkg::LOCK_BIT] = grant_ok || q.agent_lock;
               end
               ipr_pkg::ADDR_STAT:
               begin
                  d.rdata[ipr_pkg::STAT_BUSY] = (q.st != ipr_pkg::ST_IDLE);
                  d.rdata[ipr_pkg::STAT_LOCK] = q.agent_lock;
               end
               default:
                  d.rdata = ipr_pkg::RST_WORD;
            endcase
         end
      end

      // register writes; agents and direct posting land here
      if (reg_wr)
      begin
         if (pend_hit)
            d.pend[{pend_idx, 5'h00} +: 32] = reg_wdata;
         else
         begin
            case (reg_addr)
               ipr_pkg::ADDR_PRI:
                  d.pri = reg_wdata;
               ipr_pkg::ADDR_INTERRUPT_CONTROL_REGISTER:
                  d.interrupt_control_register_clr = reg_wdata[ipr_pkg::INTERRUPT_CONTROL_REGISTER_CLR_BIT];
               ipr_pkg::ADDR_LOCK:
                  d.agent_lock = reg_wdata[ipr_pkg::LOCK_BIT];
               default:
                  d.interrupt_control_register_clr = q.interrupt_control_register_clr;
            endcase
         end
      end

      // hardware handler entry tracked until its first instruction or a software ack
      if (hw_ack)
         d.hw_entry = 1'b1;
      else if (handler_first_insn || sw_ack)
         d.hw_entry = 1'b0;

      // table sequencer
      case (q.st)
         ipr_pkg::ST_IDLE:
         begin
            if (sw_ack)
            begin
               d.svc = 1'b1;
               d.st  = ipr_pkg::ST_PEEK;
            end
            else if (post_req && post_msg == ipr_pkg::MSG_POST)
            begin
               d.svc = 1'b0;
               d.vec = post_vec;
               if (post_vec <= ipr_pkg::CHECK_VEC_MAX)
                  d.st = ipr_pkg::ST_PEEK;
               else
                  d.st = ipr_pkg::ST_POST;
            end
         end
         ipr_pkg::ST_POST:
         begin
            // one-cycle update of both bits is the atomic write
            if (dev_go)
            begin
               d.pend[q.vec] = 1'b1;
               d.pri[5'(q.vec >> ipr_pkg::PRI_SHIFT)] = 1'b1;
               d.st = ipr_pkg::ST_PEEK;
            end
         end
         ipr_pkg::ST_PEEK:
         begin
            // unlocked look; a post only refreshes the priority register
            if (!q.svc || peek_exit)
               d.st = ipr_pkg::ST_SPR;
            else
               d.st = ipr_pkg::ST_LOCK;
         end
         ipr_pkg::ST_LOCK:
         begin
            // locked recheck; the word stands as written back on exit
            if (dev_go)
            begin
               d.y = pri_msb;
               if (peek_exit)
                  d.st = ipr_pkg::ST_SPR;
               else
                  d.st = ipr_pkg::ST_BYTE;
            end
         end
         ipr_pkg::ST_BYTE:
         begin
            // clear the top vector of level y, then the level if empty
            d.pri = pri_after;
            if (byte_any)
            begin
               d.pend[{q.y, 3'h0} +: 8] = byte_cleared;
               d.taken     = 1'b1;
               d.taken_vec = {q.y, byte_msb};
            end
            d.st = ipr_pkg::ST_SPR;
         end
         ipr_pkg::ST_SPR:
         begin
            // only reached from a post or a service
            d.spr = pri_msb;
            d.st  = ipr_pkg::ST_IDLE;
         end
         default:
            d.st = ipr_pkg::ST_IDLE;
      endcase
   end

   // state register, frozen while ce is low
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         q     <= '0;
         q.st  <= ipr_pkg::ST_IDLE;
         q.spr <= ipr_pkg::PRI_NONE;
      end
      else if (ce)
         q <= d;
   end

   // outputs
   assign reg_rdata    = q.rdata;
   assign busy         = (q.st != ipr_pkg::ST_IDLE);
   assign taken_valid  = q.taken;
   assign taken_vector = q.taken_vec;

   // level of the table after the byte step, seen by software via the word
   logic unused_nxt;
   assign unused_nxt = nxt_any ^ (|nxt_msb);

endmodule
`default_nettype wire

// >>> verification/ipr_resolver_assertions.sv
// ipr_resolver_assertions: port-level timing checks of the resolver.
// assumes ce stays high and a single clock domain.
`timescale 1ns/1ps
`default_nettype none
module ipr_resolver_assertions #(
   parameter int MW = 8
) (
   // clock and reset
   input wire logic          ref_clk,
   input wire logic          rst_n,
   // register port and post request
   input wire logic          reg_rd,
   input wire logic [31:0]   reg_rdata,
   input wire logic          post_req,
   input wire logic [7:0]    post_msg,
   input wire logic          busy,
   // priorities and handshakes
   input wire logic          sw_ack,
   input wire logic [4:0]    cur_pri,
   input wire logic [4:0]    hw_pend_pri,
   input wire logic          sw_int_req,
   input wire logic          hw_int_req,
   input wire logic          taken_valid,
   input wire logic          hw_ack,
   input wire logic          hw_ack_pin_timer,
   // mask
   input wire logic [MW-1:0] hardware_interrupt_mask,
   input wire logic [MW-1:0] saved_mask_local_register
);
   logic posted_q;
   logic go;
   logic entry;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   // accepted post request and handler entry
   assign go    = post_req && !busy && !sw_ack;
   assign entry = hw_ack && hw_ack_pin_timer;
   // remembers that a post was accepted since reset
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         posted_q <= 1'b0;
      else if (go && post_msg == 8'h00)
         posted_q <= 1'b1;
   end
   // hardware request follows the priority comparison
   hw_req_def_a: assert property (hw_int_req == (hw_pend_pri != 5'h00 &&
      (hw_pend_pri > cur_pri || hw_pend_pri == 5'h1F))) else $error("hw request wrong");
   rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
      else $error("read data outside its cycle");
   take_once_a: assert property (taken_valid |=> !taken_valid)
      else $error("taken pulse too long");
   take_busy_a: assert property (taken_valid |-> $past(busy))
      else $error("vector taken without table check");
   post_busy_a: assert property (go && post_msg == 8'h00 |=> busy)
      else $error("post not started");
   msg_ignore_a: assert property (go && post_msg != 8'h00 |=> !busy)
      else $error("other message acted on");
   mask_save_a: assert property (entry |=>
      saved_mask_local_register == $past(hardware_interrupt_mask)) else $error("mask not saved");
   mask_clear_a: assert property (entry |=> hardware_interrupt_mask == 0 ||
      $stable(hardware_interrupt_mask)) else $error("mask altered on entry");
   no_early_sw_a: assert property (!posted_q |-> !sw_int_req)
      else $error("software request before any post");
   busy_bound_a: assert property ($rose(busy) |-> ##[2:40] !busy)
      else $error("table check never ends");
   // main scenarios
   cover property (taken_valid);
   cover property (sw_int_req && hw_int_req);
   cover property (entry);
endmodule
`default_nettype wire

// >>> verification/ipr_core_model.sv
// ipr_core_model: core side that starts software service when asked.
// assumes busy low means the resolver takes a new request.
`timescale 1ns/1ps
`default_nettype none
module ipr_core_model (
   // clock and reset
   input wire logic       ref_clk,
   input wire logic       rst_n,
   // control from the bench
   input wire logic       en,
   input wire logic [3:0] dly,
   // resolver handshake
   input wire logic       sw_int_req,
   input wire logic       busy,
   output logic           sw_ack
);
   logic [3:0] cnt_q;
   // one-cycle ack after dly idle cycles of a standing request
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sw_ack <= 1'b0;
         cnt_q  <= 4'h0;
      end
      else
      begin
         sw_ack <= 1'b0;
         if (en && sw_int_req && !busy && !sw_ack)
         begin
            sw_ack <= (cnt_q == dly);
            cnt_q  <= (cnt_q == dly) ? 4'h0 : cnt_q + 4'h1;
         end
         else
            cnt_q <= 4'h0;
      end
   end
endmodule
`default_nettype wire

// >>> verification/interrupt_posting_priority_resolver_bench.sv
// interrupt_posting_priority_resolver_bench: drives registers, posts,
// hardware entries and service through a core model; checks results.
// assumes the resolver's register map and timing in its package.
`timescale 1ns/1ps
`default_nettype none
module interrupt_posting_priority_resolver_bench;
   logic        ref_clk, rst_n, reg_wr, reg_rd, post_req, sw_ack, en, rd_seen;
   logic        hw_ack, hw_pt, first_insn, busy, sw_int_req, hw_int_req, taken_valid;
   logic [7:0]  reg_addr, post_msg, post_vec, taken_vector, mask, saved, m;
   logic [31:0] reg_wdata, reg_rdata;
   logic [4:0]  cur_pri, hw_pend_pri;
   logic [3:0]  dly;
   logic [31:0] rd_q[$];
   logic [7:0]  tk_q[$];
   int          n_errors, checks_done, cyc, v;
   ipr_resolver #(.MW(8)) i_ipr_resolver (.ref_clk(ref_clk), .rst_n(rst_n), .ce(1'b1),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .post_req(post_req), .post_msg(post_msg), .post_vec(post_vec),
      .busy(busy), .cur_pri(cur_pri), .hw_pend_pri(hw_pend_pri), .sw_int_req(sw_int_req),
      .sw_ack(sw_ack), .taken_valid(taken_valid), .taken_vector(taken_vector),
      .hw_int_req(hw_int_req), .hw_ack(hw_ack), .hw_ack_pin_timer(hw_pt),
      .handler_first_insn(first_insn), .hardware_interrupt_mask(mask),
      .saved_mask_local_register(saved));
   ipr_core_model i_ipr_core_model (.ref_clk(ref_clk), .rst_n(rst_n), .en(en), .dly(dly),
      .sw_int_req(sw_int_req), .busy(busy), .sw_ack(sw_ack));
   // clock and hang guard
   initial
   begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk)
   begin
      cyc++;
      rd_seen <= reg_rd;
      if (cyc == 20000)
      begin
         n_errors++;
         test_done();
      end
   end
   task automatic test_done();
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         n_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // watcher: oldest note against each read answer and taken vector
   always @(negedge ref_clk)
   begin
      if (rd_seen === 1'b1)
         chk(reg_rdata, rd_q.size() > 0 ? rd_q.pop_front() : 32'hDEAD);
      if (taken_valid !== 1'b0)
         chk(32'(taken_vector), tk_q.size() > 0 ? 32'(tk_q.pop_front()) : 32'h1FF);
   end
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      rd_q.push_back(e);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
   endtask
   task automatic wait_idle();
      @(negedge ref_clk);
      for (int i = 0; i < 60 && busy !== 1'b0; i++) @(negedge ref_clk);
      chk(32'(busy), 32'h0);
   endtask
   task automatic post(input logic [7:0] mt, input logic [7:0] vc);
      @(posedge ref_clk);
      post_req <= 1'b1;
      post_msg <= mt;
      post_vec <= vc;
      @(posedge ref_clk);
      post_req <= 1'b0;
      wait_idle();
   endtask
   task automatic pri(input logic [4:0] c, input logic [4:0] h);
      @(posedge ref_clk);
      cur_pri     <= c;
      hw_pend_pri <= h;
      @(negedge ref_clk);
   endtask
   task automatic hw_entry();
      @(posedge ref_clk);
      hw_ack <= 1'b1;
      hw_pt  <= 1'b1;
      @(posedge ref_clk);
      hw_ack <= 1'b0;
      hw_pt  <= 1'b0;
      @(negedge ref_clk);
   endtask
   task automatic serve();
      @(posedge ref_clk);
      dly <= 4'($urandom % 4);
      en  <= 1'b1;
      for (int i = 0; i < 300 && tk_q.size() > 0; i++) @(negedge ref_clk);
      wait_idle();
      @(posedge ref_clk);
      en <= 1'b0;
      chk(32'(tk_q.size()), 32'h0);
   endtask
   // first instruction of the hardware handler ends its entry window
   task automatic insn();
      @(posedge ref_clk);
      first_insn <= 1'b1;
      @(posedge ref_clk);
      first_insn <= 1'b0;
   endtask
   // main sequence
   initial
   begin
      {rst_n, reg_wr, reg_rd, post_req, en, hw_ack, hw_pt, first_insn} = '0;
      {reg_addr, post_msg, post_vec, reg_wdata, dly, cur_pri, hw_pend_pri} = '0;
      void'($urandom(32'h2304));
      repeat (8) @(posedge ref_clk);
      rst_n <= 1'b1;
      pri(5'h02, 5'h00);
      rd(8'h00, 32'h0);
      rd(8'h3C, 32'h0);
      post(8'h01, 8'd40);
      rd(8'h00, 32'h0);
      post(8'h00, 8'd40);
      post(8'h00, 8'd41);
      rd(8'h00, 32'h20);
      rd(8'h08, 32'h300);
      chk(32'(sw_int_req), 32'h1);
      pri(5'h02, 5'h05);
      chk(32'(sw_int_req), 32'h0);
      chk(32'(hw_int_req), 32'h1);
      pri(5'h05, 5'h00);
      chk(32'(sw_int_req), 32'h0);
      chk(32'(hw_int_req), 32'h0);
      pri(5'h02, 5'h00);
      chk(32'(sw_int_req), 32'h1);
      tk_q.push_back(8'd41);
      tk_q.push_back(8'd40);
      serve();
      rd(8'h00, 32'h0);
      // external agent posts under the lock, then a forced check
      v = 64 + ($urandom % 184);
      rd(8'h2C, 32'h1);
      rd(8'h04 + 8'(4 * (v >> 5)), 32'h0);
      wr(8'h04 + 8'(4 * (v >> 5)), 32'h1 << (v % 32));
      wr(8'h00, 32'h1 << (v >> 3));
      wr(8'h2C, 32'h0);
      chk(32'(sw_int_req), 32'h0);
      post(8'h00, 8'h03);
      tk_q.push_back(8'(v));
      serve();
      // mask save, with and without the clear option
      m = 8'($urandom);
      wr(8'h28, 32'(m));
      rd(8'h28, 32'(m));
      wr(8'h24, 32'h0);
      hw_entry();
      chk(32'(saved), 32'(m));
      chk(32'(mask), 32'(m));
      m = 8'($urandom);
      wr(8'h28, 32'(m));
      wr(8'h24, 32'h1);
      hw_entry();
      chk(32'(saved), 32'(m));
      rd(8'h28, 32'h0);
      insn();
      // priority-31 tie: hardware first, software before its first insn
      pri(5'h1F, 5'h1F);
      post(8'h00, 8'd250);
      chk(32'(sw_int_req), 32'h0);
      chk(32'(hw_int_req), 32'h1);
      hw_entry();
      chk(32'(sw_int_req), 32'h1);
      tk_q.push_back(8'd250);
      serve();
      insn();
      pri(5'h02, 5'h00);
      repeat (3) @(negedge ref_clk);
      chk(32'(rd_q.size()), 32'h0);
      test_done();
   end
endmodule
bind ipr_resolver ipr_resolver_assertions #(.MW(MW)) i_ipr_resolver_assertions (.ref_clk,
   .rst_n, .reg_rd, .reg_rdata, .post_req, .post_msg, .busy, .sw_ack, .cur_pri, .hw_pend_pri,
   .sw_int_req, .hw_int_req, .taken_valid, .hw_ack, .hw_ack_pin_timer,
   .hardware_interrupt_mask, .saved_mask_local_register);
`default_nettype wire
